// ---- hdl/dcr_pkg.sv ----
// constants and types shared by the downconverter configuration registers
package dcr_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int DCR_NUM_REGS = 13;
    localparam int DCR_R_SRC    = 0;
    localparam int DCR_R_DEC    = 1;
    localparam int DCR_R_GAIN   = 2;
    localparam int DCR_R_P0IQ   = 3;
    localparam int DCR_R_OSC0   = 4;
    localparam int DCR_R_P1IQ   = 8;
    localparam int DCR_R_OSC1   = 9;

    localparam logic [7:0] DCR_REG_IDX [DCR_NUM_REGS] = '{
        8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
        8'h2E, 8'h31, 8'h32, 8'h33, 8'h34};
    // writable bits, reserved bits hold zero
    localparam logic [7:0] DCR_REG_MASK [DCR_NUM_REGS] = '{
        8'h1A, 8'hF8, 8'hEE, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h18, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] DCR_REG_RESET = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int DCR_BIT_DOWNCONVERTER_ENABLE   = 1;
    localparam int DCR_SEL_LSB      = 3;
    localparam int DCR_SEL_W        = 2;
    localparam int DCR_BIT_MUX_EN   = 7;
    localparam int DCR_DEC_LSB      = 4;
    localparam int DCR_DEC_W        = 3;
    localparam int DCR_BIT_MODE     = 3;
    localparam int DCR_GAIN0_LSB    = 6;
    localparam int DCR_GAIN1_LSB    = 2;
    localparam int DCR_GAIN_W       = 2;
    localparam int DCR_BIT_OSC0_RST = 5;
    localparam int DCR_BIT_OSC1_RST = 1;
    localparam int DCR_BIT_IQ_SWAP  = 4;
    localparam int DCR_BIT_QUAD_DEL = 3;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] DCR_GAIN_6DB   = 2'h2;
    localparam logic [2:0] DCR_DEC_MAX    = 3'h5;
    localparam logic [5:0] DCR_RATIO_NONE = 6'h01;
    localparam logic [1:0] DCR_SEL_SPLIT  = 2'h0;
    localparam logic [1:0] DCR_SEL_ALL_A  = 2'h1;
    localparam logic [1:0] DCR_SEL_ALL_B  = 2'h2;

    typedef enum logic [1:0] {
        DCR_SRC_A   = 2'h0,
        DCR_SRC_B   = 2'h1,
        DCR_SRC_AVG = 2'h2
    } dcr_src_e;

    // ****************************************
    // bus
    // ****************************************
    localparam int         DCR_DATA_W     = 32;
    localparam int         DCR_IDX_LSB    = 2;
    localparam int         DCR_IDX_W      = 8;
    localparam logic [2:0] DCR_HSIZE_WORD = 3'h2;
    localparam logic       DCR_HRESP_OKAY = 1'b0;
    localparam logic [7:0] DCR_IDX_NONE   = 8'hFF;

endpackage : dcr_pkg

// ---- hdl/dcr_bus_if.sv ----
// register access strobes between the bus slave and the register bank
`timescale 1ns/1ps
interface dcr_bus_if;
    logic        wrStb;
    logic [7:0]  idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wrStb, output idx, output wdata, input rdata);
    modport regs  (input wrStb, input idx, input wdata, output rdata);
endinterface : dcr_bus_if

// ---- hdl/dcr_ahb_slave.sv ----
// AHB-Lite slave front end: zero-wait writes, one wait state on reads
`timescale 1ns/1ps
module dcr_ahb_slave (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    dcr_bus_if.slave         bus
);
    import dcr_pkg::*;

    logic                 wrPend_reg;
    logic                 rdPend_reg;
    logic [DCR_IDX_W-1:0] idx_reg;

    // ****************************************
    // address phase decode
    // ****************************************
    wire addrTake   = hsel & htrans[1] & hready;
    wire addrMapped = (haddr[31:DCR_IDX_LSB+DCR_IDX_W] == '0);
    wire wordSize   = (hsize == DCR_HSIZE_WORD);
    wire [DCR_IDX_W-1:0] idxNext = addrMapped ? haddr[DCR_IDX_LSB +: DCR_IDX_W] : DCR_IDX_NONE;

    assign bus.wrStb = wrPend_reg;
    assign bus.idx   = idx_reg;
    assign bus.wdata = hwdata;

    // ****************************************
    // data phase
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            idx_reg    <= DCR_IDX_NONE;
            hreadyout  <= 1'b1;
        end else if (addrTake) begin
            wrPend_reg <= hwrite & wordSize;
            rdPend_reg <= ~hwrite;
            idx_reg    <= idxNext;
            hreadyout  <= hwrite;
        end else begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            hreadyout  <= 1'b1;
        end
    end

    // read data is sampled in the wait cycle, after any earlier write landed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
            hresp  <= DCR_HRESP_OKAY;
        end else begin
            hresp <= DCR_HRESP_OKAY;
            if (rdPend_reg) begin
                hrdata <= bus.rdata;
            end
        end
    end

endmodule : dcr_ahb_slave

// ---- hdl/dcr_config_regs.sv ----
// configuration register bank for the two downconverter paths
// Operation
// - source selection acts only while the source mux enable bit is set
// - decimation ratio field codes 000..101 give ratios 1,2,4,8,16,32
// - mode bit is shared by both paths: 0 complex, 1 real
// - path0 gain code 10 adds 6 dB, 00 adds nothing
// - path1 gain code 10 adds 6 dB, 00 adds nothing
// - toggling osc0 reset bit resets path0 phase and loads osc0 word
// - toggling osc1 reset bit resets path1 phase and loads osc1 word
// - path0 swap bit swaps I and Q output order of path0
// - path0 delay bit delays path0 quadrature output by one sample
// - path1 swap bit swaps I and Q output order of path1
// - path1 delay bit delays path1 quadrature output by one sample
// - osc0 word assembled from four byte registers, low byte first
// - osc1 word assembled from four byte registers, low byte first
// - select 00 split, 01 A to both, 10 B to both, 11 average
// - downconverter enable bit turns both paths on or off
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module dcr_config_regs (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    output logic                   downconverterEnable,
    output dcr_pkg::dcr_src_e      path0Source,
    output dcr_pkg::dcr_src_e      path1Source,
    output logic [5:0]             decimationRatio,
    output logic                   downconverterMode,
    output logic                   path0GainBoost,
    output logic                   path1GainBoost,
    output logic                   osc0PhaseReset,
    output logic [31:0]            osc0FreqWord,
    output logic                   osc1PhaseReset,
    output logic [31:0]            osc1FreqWord,
    output logic                   path0IqSwap,
    output logic                   path0QuadDelay,
    output logic                   path1IqSwap,
    output logic                   path1QuadDelay
);
    import dcr_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rstSync1_reg;
    logic rstSync2_reg;
    wire  rstn = rstSync2_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end

    // ****************************************
    // bus slave
    // ****************************************
    dcr_bus_if regBus ();

    dcr_ahb_slave u_slave (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .bus       (regBus)
    );

    // ****************************************
    // register file
    // ****************************************
    logic [7:0]        regVal  [DCR_NUM_REGS];
    logic [7:0]        rdChain [DCR_NUM_REGS+1];
    logic [DCR_NUM_REGS-1:0] regHit;

    assign rdChain[0] = 8'h00;

    generate
        for (genvar i = 0; i < DCR_NUM_REGS; i++) begin : g_reg
            assign regHit[i]    = (regBus.idx == DCR_REG_IDX[i]);
            assign rdChain[i+1] = rdChain[i] | (regHit[i] ? regVal[i] : 8'h00);

            // reserved bits are dropped on write and read back as zero
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    regVal[i] <= DCR_REG_RESET;
                end else if (regBus.wrStb && regHit[i]) begin
                    regVal[i] <= regBus.wdata[7:0] & DCR_REG_MASK[i];
                end
            end
        end
    endgenerate

    // unmapped indices fall through the chain and read as zero
    assign regBus.rdata = {{(DCR_DATA_W-8){1'b0}}, rdChain[DCR_NUM_REGS]};

    // ****************************************
    // field extraction
    // ****************************************
    wire                 enBit     = regVal[DCR_R_SRC][DCR_BIT_DOWNCONVERTER_ENABLE];
    wire [DCR_SEL_W-1:0] selField  = regVal[DCR_R_SRC][DCR_SEL_LSB +: DCR_SEL_W];
    wire                 muxEn     = regVal[DCR_R_DEC][DCR_BIT_MUX_EN];
    wire [DCR_DEC_W-1:0] decField  = regVal[DCR_R_DEC][DCR_DEC_LSB +: DCR_DEC_W];
    wire                 modeBit   = regVal[DCR_R_DEC][DCR_BIT_MODE];
    wire [DCR_GAIN_W-1:0] gain0    = regVal[DCR_R_GAIN][DCR_GAIN0_LSB +: DCR_GAIN_W];
    wire [DCR_GAIN_W-1:0] gain1    = regVal[DCR_R_GAIN][DCR_GAIN1_LSB +: DCR_GAIN_W];
    wire                 osc0Bit   = regVal[DCR_R_GAIN][DCR_BIT_OSC0_RST];
    wire                 osc1Bit   = regVal[DCR_R_GAIN][DCR_BIT_OSC1_RST];
    wire                 swap0Bit  = regVal[DCR_R_P0IQ][DCR_BIT_IQ_SWAP];
    wire                 delay0Bit = regVal[DCR_R_P0IQ][DCR_BIT_QUAD_DEL];
    wire                 swap1Bit  = regVal[DCR_R_P1IQ][DCR_BIT_IQ_SWAP];
    wire                 delay1Bit = regVal[DCR_R_P1IQ][DCR_BIT_QUAD_DEL];

    // frequency words, byte 3 is the most significant
    wire [31:0] osc0WordRaw = {regVal[DCR_R_OSC0+3], regVal[DCR_R_OSC0+2],
                               regVal[DCR_R_OSC0+1], regVal[DCR_R_OSC0]};
    wire [31:0] osc1WordRaw = {regVal[DCR_R_OSC1+3], regVal[DCR_R_OSC1+2],
                               regVal[DCR_R_OSC1+1], regVal[DCR_R_OSC1]};

    // ****************************************
    // derived controls
    // ****************************************
    // a disabled mux falls back to the straight split routing
    wire [DCR_SEL_W-1:0] selEff = muxEn ? selField : DCR_SEL_SPLIT;

    wire dcr_src_e p0SrcNext = (selEff == DCR_SEL_SPLIT) ? DCR_SRC_A :
                               (selEff == DCR_SEL_ALL_A) ? DCR_SRC_A :
                               (selEff == DCR_SEL_ALL_B) ? DCR_SRC_B :
                                                           DCR_SRC_AVG;
    wire dcr_src_e p1SrcNext = (selEff == DCR_SEL_SPLIT) ? DCR_SRC_B :
                               (selEff == DCR_SEL_ALL_A) ? DCR_SRC_A :
                               (selEff == DCR_SEL_ALL_B) ? DCR_SRC_B :
                                                           DCR_SRC_AVG;

    // codes above the last ratio act as no decimation
    wire [5:0] ratioNext = (decField <= DCR_DEC_MAX) ?
                           (DCR_RATIO_NONE << decField) : DCR_RATIO_NONE;

    wire gain0Next = (gain0 == DCR_GAIN_6DB);
    wire gain1Next = (gain1 == DCR_GAIN_6DB);

    // ****************************************
    // oscillator reset on toggle
    // ****************************************
    logic osc0Prev_reg;
    logic osc1Prev_reg;

    wire osc0Toggle = osc0Bit ^ osc0Prev_reg;
    wire osc1Toggle = osc1Bit ^ osc1Prev_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc0Prev_reg   <= 1'b0;
            osc1Prev_reg   <= 1'b0;
            osc0PhaseReset <= 1'b0;
            osc1PhaseReset <= 1'b0;
        end else begin
            osc0Prev_reg   <= osc0Bit;
            osc1Prev_reg   <= osc1Bit;
            osc0PhaseReset <= osc0Toggle;
            osc1PhaseReset <= osc1Toggle;
        end
    end

    // the word in use changes only on a toggle, later byte writes wait
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc0FreqWord <= 32'h0000_0000;
            osc1FreqWord <= 32'h0000_0000;
        end else begin
            if (osc0Toggle) begin
                osc0FreqWord <= osc0WordRaw;
            end
            if (osc1Toggle) begin
                osc1FreqWord <= osc1WordRaw;
            end
        end
    end

    // ****************************************
    // path controls
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            downconverterEnable <= 1'b0;
            path0Source         <= DCR_SRC_A;
            path1Source         <= DCR_SRC_B;
            decimationRatio     <= DCR_RATIO_NONE;
            downconverterMode   <= 1'b0;
        end else begin
            downconverterEnable <= enBit;
            path0Source         <= p0SrcNext;
            path1Source         <= p1SrcNext;
            decimationRatio     <= ratioNext;
            downconverterMode   <= modeBit;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            path0GainBoost <= 1'b0;
            path1GainBoost <= 1'b0;
            path0IqSwap    <= 1'b0;
            path0QuadDelay <= 1'b0;
            path1IqSwap    <= 1'b0;
            path1QuadDelay <= 1'b0;
        end else begin
            path0GainBoost <= gain0Next;
            path1GainBoost <= gain1Next;
            path0IqSwap    <= swap0Bit;
            path0QuadDelay <= delay0Bit;
            path1IqSwap    <= swap1Bit;
            path1QuadDelay <= delay1Bit;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_osc0_toggle;
        $changed(osc0Bit);
    endsequence

    sequence s_osc0_load;
        osc0PhaseReset && (osc0FreqWord == $past(osc0WordRaw));
    endsequence

    sequence s_osc1_toggle;
        $changed(osc1Bit);
    endsequence

    sequence s_osc1_load;
        osc1PhaseReset && (osc1FreqWord == $past(osc1WordRaw));
    endsequence

    a_mux_off_split: assert property (
        !muxEn |=> (path0Source == DCR_SRC_A) && (path1Source == DCR_SRC_B))
        else $error("disabled mux did not give split routing");

    a_dec_ratio_map: assert property (
        (decField == 3'h5) |=> (decimationRatio == 6'h20))
        else $error("decimation code 101 not ratio 32");

    a_dec_ratio_two: assert property (
        (decField == 3'h1) ##1 (decField == 3'h1) |=> (decimationRatio == 6'h02))
        else $error("decimation code 001 not ratio 2");

    a_mode_follows: assert property (
        $changed(modeBit) |=> (downconverterMode == $past(modeBit)))
        else $error("mode output did not follow mode bit");

    a_gain0_boost: assert property (
        (gain0 == 2'h2) |=> path0GainBoost ##0 $stable(osc0FreqWord) or path0GainBoost)
        else $error("path0 gain code 10 not applied");

    a_gain0_none: assert property (
        (gain0 == 2'h0) |=> !path0GainBoost)
        else $error("path0 gain added with code 00");

    a_gain1_boost: assert property (
        (gain1 == 2'h2) |=> path1GainBoost)
        else $error("path1 gain code 10 not applied");

    a_gain1_none: assert property (
        (gain1 == 2'h0) |=> !path1GainBoost)
        else $error("path1 gain added with code 00");

    a_osc0_toggle: assert property (
        s_osc0_toggle |=> s_osc0_load)
        else $error("osc0 toggle did not reset phase and load word");

    a_osc0_quiet: assert property (
        $stable(osc0Bit) |=> !osc0PhaseReset && $stable(osc0FreqWord))
        else $error("osc0 reset without toggle");

    a_osc1_toggle: assert property (
        s_osc1_toggle |=> s_osc1_load)
        else $error("osc1 toggle did not reset phase and load word");

    a_osc1_quiet: assert property (
        $stable(osc1Bit) |=> !osc1PhaseReset && $stable(osc1FreqWord))
        else $error("osc1 reset without toggle");

    a_path0_swap: assert property (
        swap0Bit ##1 swap0Bit |-> path0IqSwap)
        else $error("path0 swap not applied");

    a_path0_delay: assert property (
        delay0Bit |=> path0QuadDelay)
        else $error("path0 quadrature delay not applied");

    a_path1_swap: assert property (
        swap1Bit |=> path1IqSwap)
        else $error("path1 swap not applied");

    a_path1_delay: assert property (
        !delay1Bit |=> !path1QuadDelay)
        else $error("path1 quadrature delay set without bit");

    a_osc0_top_byte: assert property (
        regBus.wrStb && (regBus.idx == 8'h2D)
        |=> (osc0WordRaw[31:24] == $past(regBus.wdata[7:0])))
        else $error("osc0 top byte not placed in bits 31:24");

    a_osc1_low_byte: assert property (
        regBus.wrStb && (regBus.idx == 8'h31)
        |=> (osc1WordRaw[7:0] == $past(regBus.wdata[7:0])))
        else $error("osc1 low byte not placed in bits 7:0");

    a_avg_routing: assert property (
        muxEn && (selField == 2'h3)
        |=> (path0Source == DCR_SRC_AVG) && (path1Source == DCR_SRC_AVG))
        else $error("average selection not routed to both paths");

    a_enable_follow: assert property (
        !enBit [*2] |-> !downconverterEnable)
        else $error("paths enabled while enable bit clear");

    a_reset_zero: assert property (
        $rose(rstn) |-> (osc0WordRaw == 32'h0000_0000) && !downconverterMode
                        && (decimationRatio == 6'h01) && !path0IqSwap)
        else $error("fields not zero after reset");

endmodule : dcr_config_regs

// ---- test/tb_downconverter_config_regs.sv ----
// self-checking bench for the downconverter configuration registers
`timescale 1ns/1ps
module tb_downconverter_config_regs;
    import dcr_pkg::*;

    `define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin errorCnt++; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

    // ****************************************
    // signals and tables
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0000_0000;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = DCR_HSIZE_WORD;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic        hreadyout, hresp, downconverterEnable, downconverterMode;
    logic [31:0] hrdata, osc0FreqWord, osc1FreqWord, rdVal, word, prev;
    dcr_src_e    path0Source, path1Source;
    logic [5:0]  decimationRatio;
    logic        path0GainBoost, path1GainBoost, osc0PhaseReset, osc1PhaseReset;
    logic        path0IqSwap, path0QuadDelay, path1IqSwap, path1QuadDelay;
    int          errorCnt = 0;
    int          nTests   = 0;
    int          oscPulses [2] = '{0, 0};
    logic [31:0] oscLoaded [2];
    int          base, other;

    localparam dcr_src_e   SRC0 [4] = '{DCR_SRC_A, DCR_SRC_A, DCR_SRC_B, DCR_SRC_AVG};
    localparam dcr_src_e   SRC1 [4] = '{DCR_SRC_B, DCR_SRC_A, DCR_SRC_B, DCR_SRC_AVG};
    localparam logic [7:0] GAINV [4] = '{8'h80, 8'h08, 8'h4C, 8'h88};
    localparam logic [7:0] OSCBASE [2] = '{8'h2A, 8'h31};
    localparam logic [7:0] RSTBIT [2] = '{8'h20, 8'h02};
    localparam logic [31:0] WORDS [4] = '{32'h9ABC_DEF0, 32'h1357_9BDF,
                                          32'hA5C3_1E70, 32'h0F1E_2D3C};

    dcr_config_regs u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .downconverterEnable(downconverterEnable), .path0Source(path0Source),
        .path1Source(path1Source), .decimationRatio(decimationRatio),
        .downconverterMode(downconverterMode), .path0GainBoost(path0GainBoost),
        .path1GainBoost(path1GainBoost), .osc0PhaseReset(osc0PhaseReset),
        .osc0FreqWord(osc0FreqWord), .osc1PhaseReset(osc1PhaseReset),
        .osc1FreqWord(osc1FreqWord), .path0IqSwap(path0IqSwap),
        .path0QuadDelay(path0QuadDelay), .path1IqSwap(path1IqSwap),
        .path1QuadDelay(path1QuadDelay)
    );

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // phase reset pulses counted, word captured while the pulse stands
    always @(posedge sys_clk) begin
        if (osc0PhaseReset === 1'b1) begin
            oscPulses[0]++;
            oscLoaded[0] = osc0FreqWord;
        end
        if (osc1PhaseReset === 1'b1) begin
            oscPulses[1]++;
            oscLoaded[1] = osc1FreqWord;
        end
    end

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic busXfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                           input logic [2:0] sz, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= sz;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : busXfer

    task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
        busXfer(1'b1, idx, d, DCR_HSIZE_WORD, rdVal);
    endtask : wrReg

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        busXfer(1'b0, idx, 8'h00, DCR_HSIZE_WORD, rdVal);
        `CHK("register read", exp, rdVal)
        `CHK("response", DCR_HRESP_OKAY, hresp)
    endtask : rdChk

    // control outputs lag the register by one clock
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic reportAndStop();
        $display("comparisons %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : reportAndStop

    initial begin
        repeat (20000) @(posedge sys_clk);
        errorCnt++;
        reportAndStop();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("ratio at reset", 6'h01, decimationRatio)
        `CHK("path0 source at reset", DCR_SRC_A, path0Source)
        `CHK("path1 source at reset", DCR_SRC_B, path1Source)
        for (int i = 0; i < DCR_NUM_REGS; i++) begin
            rdChk(DCR_REG_IDX[i], 32'h0000_0000);
        end
        for (int i = 0; i < DCR_NUM_REGS; i++) begin
            wrReg(DCR_REG_IDX[i], 8'hFF);
            rdChk(DCR_REG_IDX[i], {24'h00_0000, DCR_REG_MASK[i]});
            wrReg(DCR_REG_IDX[i], 8'h00);
        end
        // unmapped place and a byte-sized write are both dropped
        wrReg(8'h30, 8'hFF);
        rdChk(8'h30, 32'h0000_0000);
        busXfer(1'b1, DCR_REG_IDX[DCR_R_P0IQ], 8'h18, 3'h0, rdVal);
        rdChk(DCR_REG_IDX[DCR_R_P0IQ], 32'h0000_0000);
        for (int s = 0; s < 4; s++) begin
            wrReg(DCR_REG_IDX[DCR_R_SRC], 8'(s << 3) | 8'h02);
            wrReg(DCR_REG_IDX[DCR_R_DEC], 8'h00);
            settle();
            `CHK("path0 source mux off", DCR_SRC_A, path0Source)
            `CHK("path1 source mux off", DCR_SRC_B, path1Source)
            `CHK("enable on", 1'b1, downconverterEnable)
            wrReg(DCR_REG_IDX[DCR_R_DEC], 8'h80);
            settle();
            `CHK("path0 source", SRC0[s], path0Source)
            `CHK("path1 source", SRC1[s], path1Source)
        end
        wrReg(DCR_REG_IDX[DCR_R_SRC], 8'h00);
        settle();
        `CHK("enable off", 1'b0, downconverterEnable)
        for (int c = 0; c < 8; c++) begin
            wrReg(DCR_REG_IDX[DCR_R_DEC], 8'((c << 4) | ((c & 1) << 3)));
            settle();
            `CHK("decimation ratio", 6'(c < 6 ? 1 << c : 1), decimationRatio)
            `CHK("mode", 1'(c & 1), downconverterMode)
        end
        wrReg(DCR_REG_IDX[DCR_R_DEC], 8'h00);
        for (int g = 0; g < 4; g++) begin
            wrReg(DCR_REG_IDX[DCR_R_GAIN], GAINV[g]);
            settle();
            `CHK("path0 gain", GAINV[g][7:6] == 2'h2, path0GainBoost)
            `CHK("path1 gain", GAINV[g][3:2] == 2'h2, path1GainBoost)
        end
        wrReg(DCR_REG_IDX[DCR_R_GAIN], 8'h00);
        for (int q = 0; q < 4; q++) begin
            wrReg(DCR_REG_IDX[DCR_R_P0IQ], 8'(q << 3));
            wrReg(DCR_REG_IDX[DCR_R_P1IQ], 8'((3 - q) << 3));
            settle();
            `CHK("path0 swap", 1'(q >> 1), path0IqSwap)
            `CHK("path0 delay", 1'(q), path0QuadDelay)
            `CHK("path1 swap", 1'((3 - q) >> 1), path1IqSwap)
            `CHK("path1 delay", 1'(3 - q), path1QuadDelay)
        end
        for (int k = 0; k < 2; k++) begin
            prev = 32'h0000_0000;
            for (int w = 0; w < 2; w++) begin
                base  = oscPulses[k];
                other = oscPulses[1 - k];
                word  = WORDS[2 * k + w];
                for (int b = 0; b < 4; b++) begin
                    wrReg(OSCBASE[k] + 8'(b), word[8 * b +: 8]);
                end
                settle();
                `CHK("word before toggle", prev, k ? osc1FreqWord : osc0FreqWord)
                wrReg(DCR_REG_IDX[DCR_R_GAIN], w ? 8'h00 : RSTBIT[k]);
                settle();
                `CHK("phase reset pulses", base + 1, oscPulses[k])
                `CHK("other oscillator", other, oscPulses[1 - k])
                `CHK("word loaded", word, k ? osc1FreqWord : osc0FreqWord)
                `CHK("word at pulse", word, oscLoaded[k])
                rdChk(DCR_REG_IDX[DCR_R_GAIN], w ? 32'h0000_0000 : {24'h0, RSTBIT[k]});
                prev = word;
            end
        end
        // second reset in mid-run clears the bank again
        wrReg(DCR_REG_IDX[DCR_R_DEC], 8'hB0);
        settle();
        `CHK("ratio before reset", 6'h08, decimationRatio)
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdChk(DCR_REG_IDX[DCR_R_DEC], 32'h0000_0000);
        `CHK("ratio after reset", 6'h01, decimationRatio)
        reportAndStop();
    end

endmodule : tb_downconverter_config_regs
